// ==== lcd_core.sv ====
// Literal and control instruction decoder/executor with its register slave
//
// Summary of operation
// - Add literal to W, update carry, digit carry and zero, one cycle.
// - AND literal into W, zero flag only, one cycle.
// - Call pushes return address, jumps to 11-bit target, two cycles, flags kept.
// - Jump to 11-bit target, two cycles, flags kept.
// - Watchdog clear word pulses clear, sets timeout and powerdown flags, one cycle.
// - OR literal into W, zero flag, one cycle.
// - Load literal into W, opcode bits 9:8 ignored, no flags, one cycle.
// - Interrupt return pops the stack, re-enables interrupts, two cycles.
// - Return with literal loads W and pops the stack, two cycles.
// - Plain return pops the stack, two cycles, flags kept.
// - Standby word sets timeout, clears powerdown, enters sleep, one cycle.
// - Subtract W from literal, update carry, digit carry and zero, one cycle.
// - XOR literal into W, zero flag only.
// - Register XOR with W goes to W when d is 0, file when 1.
// - Read-modify-write of the port takes the pin levels, not the latch.
// - Writing timer zero clears the prescaler when it is assigned to the timer.
// - Program counter changes take two cycles, second one a no-operation.
//
// The AHB-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`default_nettype none
`include "lcd_cfg.svh"

module lcd_core #(
  parameter int PC_W = `LCD_PC_W
) (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  // AHB-Lite slave
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic [31:0]             hrdata,
  output logic                    hresp,
  // Program memory
  output logic [PC_W-1:0]         prog_addr,
  input  wire logic [13:0]        prog_data,
  // Port and system
  input  wire logic [7:0]         port_pin_in,
  output logic [7:0]              port_out,
  output logic                    wdt_clear,
  output logic                    sleep_active
);

  import lcd_pkg::*;

  // ----------------------------------------------------------------
  // State and helpers
  // ----------------------------------------------------------------
  lcd_state_t   r;
  lcd_state_t   n;
  lcd_op_t      op;
  lcd_alu_res_t alu;
  logic [7:0]   ram [`LCD_RAM_WORDS];
  logic [7:0]   fval;
  logic [6:0]   faddr;
  logic         to_file;
  logic         ram_we;
  logic         push;
  logic         pop;
  logic [PC_W-1:0] stack_top;
  logic [PC_W-1:0] pc_inc;
  logic [PC_W-1:0] target;
  logic         tick;
  logic [7:0]   rate_mask;
  logic         addr_phase;
  logic [31:0]  status_word;

  assign op      = lcd_decode(prog_data);
  assign faddr   = prog_data[6:0];
  assign to_file = prog_data[7];
  assign pc_inc  = r.pc + PC_W'(1);
  // Upper counter bits are kept, low eleven come from the word
  assign target  = {r.pc[PC_W-1:11], prog_data[10:0]};

  // ----------------------------------------------------------------
  // File operand
  // ----------------------------------------------------------------
  always_comb
  begin
    if (faddr == `LCD_FILE_PORT)
      fval = port_pin_in;
    else if (faddr == `LCD_FILE_TIMER)
      fval = r.timer_zero_register;
    else
      fval = ram[faddr];
  end

  lcd_alu u_alu (
    .op   (op),
    .lit  (prog_data[7:0]),
    .w    (r.w),
    .fval (fval),
    .res  (alu)
  );

  lcd_stack #(
    .DEPTH (`LCD_STACK_DEPTH),
    .WIDTH (PC_W)
  ) u_stack (
    .hclk    (hclk),
    .hresetn (hresetn),
    .push    (push),
    .pop     (pop),
    .din     (pc_inc),
    .top     (stack_top)
  );

  // ----------------------------------------------------------------
  // Timer zero prescaler
  // ----------------------------------------------------------------
  // Rate 1:2 to 1:256; unassigned prescaler leaves the timer at 1:1
  assign rate_mask = 8'((9'h002 << r.ps) - 9'h001);
  assign tick      = r.psa_t0 ? ((r.presc & rate_mask) == rate_mask) : 1'b1;

  assign addr_phase = hsel && htrans[1] && hready;

  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[`LCD_ST_C]     = r.c;
    status_word[`LCD_ST_DC]    = r.dc;
    status_word[`LCD_ST_Z]     = r.z;
    status_word[`LCD_ST_PD]    = r.powerdown_flag;
    status_word[`LCD_ST_TO]    = r.timeout_flag;
    status_word[`LCD_ST_GIE]   = r.gie;
    status_word[`LCD_ST_SLEEP] = (r.fsm == st_sleep);
    status_word[`LCD_ST_RUN]   = (r.fsm != st_halt);
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    n           = r;
    n.wdt_clear = 1'b0;
    push        = 1'b0;
    pop         = 1'b0;
    ram_we      = 1'b0;
    n.presc     = r.psa_t0 ? r.presc + 8'h01 : r.presc;
    if (tick)
      n.timer_zero_register = r.timer_zero_register + 8'h01;

    unique case (r.fsm)
      st_halt:
      begin
        if (r.run)
          n.fsm = st_exec;
      end
      st_flush:
      begin
        // Word fetched at the new address is discarded here
        n.fsm = r.run ? st_exec : st_halt;
      end
      st_sleep:
      begin
        n.fsm = st_sleep;
      end
      st_exec:
      begin
        if (!r.run)
          n.fsm = st_halt;
        else
        begin
          n.pc = pc_inc;
          unique case (op)
            add_literal_op, literal_subtract_op:
            begin
              n.w  = alu.value;
              n.c  = alu.c;
              n.dc = alu.dc;
              n.z  = alu.z;
            end
            and_literal_op, or_literal_op, xor_literal_op:
            begin
              n.w = alu.value;
              n.z = alu.z;
            end
            load_literal_op:
              n.w = alu.value;
            xor_register_op:
            begin
              n.z = alu.z;
              if (!to_file)
                n.w = alu.value;
              else if (faddr == `LCD_FILE_PORT)
                n.port_latch = alu.value;
              else if (faddr == `LCD_FILE_TIMER)
              begin
                n.timer_zero_register = alu.value;
                if (r.psa_t0)
                  n.presc = 8'h00;
              end
              else
                ram_we = 1'b1;
            end
            call_op:
            begin
              push  = 1'b1;
              n.pc  = target;
              n.fsm = st_flush;
            end
            jump_op:
            begin
              n.pc  = target;
              n.fsm = st_flush;
            end
            return_with_literal_op:
            begin
              pop   = 1'b1;
              n.w   = alu.value;
              n.pc  = stack_top;
              n.fsm = st_flush;
            end
            return_op:
            begin
              pop   = 1'b1;
              n.pc  = stack_top;
              n.fsm = st_flush;
            end
            interrupt_return_op:
            begin
              pop   = 1'b1;
              n.gie = 1'b1;
              n.pc  = stack_top;
              n.fsm = st_flush;
            end
            watchdog_clear_op:
            begin
              n.wdt_clear      = 1'b1;
              n.timeout_flag   = 1'b1;
              n.powerdown_flag = 1'b1;
            end
            sleep_op:
            begin
              n.wdt_clear      = 1'b1;
              n.timeout_flag   = 1'b1;
              n.powerdown_flag = 1'b0;
              n.fsm            = st_sleep;
            end
            no_operation:
              n.pc = pc_inc;
          endcase
        end
      end
    endcase

    // ----------------------------------------------------------------
    // Bus data phase; a bus write overrides a core write in the same cycle
    // ----------------------------------------------------------------
    if (r.bus_wr)
    begin
      unique case (r.bus_addr)
        `LCD_OFF_CTRL:
        begin
          n.run    = hwdata[`LCD_CTRL_RUN];
          n.psa_t0 = hwdata[`LCD_CTRL_PSA_T0];
          n.ps     = hwdata[`LCD_CTRL_PS_HI:`LCD_CTRL_PS_LO];
          // Wake is a strobe, not stored
          if (hwdata[`LCD_CTRL_WAKE] && r.fsm == st_sleep)
            n.fsm = r.run ? st_exec : st_halt;
        end
        `LCD_OFF_TIMER:
        begin
          n.timer_zero_register = hwdata[7:0];
          if (r.psa_t0)
            n.presc = 8'h00;
        end
        `LCD_OFF_PORT:
          n.port_latch = hwdata[7:0];
        default:
          n.port_latch = n.port_latch;
      endcase
    end

    // ----------------------------------------------------------------
    // Bus address phase; read data is registered here for zero wait
    // ----------------------------------------------------------------
    n.bus_wr   = addr_phase && hwrite;
    n.bus_addr = haddr[7:0];
    if (addr_phase && !hwrite)
    begin
      unique case (haddr[7:0])
        `LCD_OFF_CTRL:
          n.hrdata = {26'h0, 1'b0, r.ps, r.psa_t0, r.run};
        `LCD_OFF_STATUS:
          n.hrdata = status_word;
        `LCD_OFF_WREG:
          n.hrdata = {24'h0, r.w};
        `LCD_OFF_PC:
          n.hrdata = {{(32 - PC_W){1'b0}}, r.pc};
        `LCD_OFF_TIMER:
          n.hrdata = {24'h0, r.timer_zero_register};
        `LCD_OFF_PORT:
          n.hrdata = {24'h0, r.port_latch};
        default:
          n.hrdata = 32'h0000_0000;
      endcase
    end
    else
      n.hrdata = 32'h0000_0000;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      r                     <= '0;
      r.fsm                 <= st_halt;
      r.timeout_flag        <= 1'b1;
      r.powerdown_flag      <= 1'b1;
      r.ps                  <= `LCD_PS_RESET;
    end
    else
      r <= n;
  end

  // No reset: file contents are undefined until written
  always_ff @(posedge hclk)
  begin
    if (ram_we)
      ram[faddr] <= alu.value;
  end

  assign hreadyout    = 1'b1;
  assign hresp        = 1'b0;
  assign hrdata       = r.hrdata;
  assign prog_addr    = r.pc;
  assign port_out     = r.port_latch;
  assign wdt_clear    = r.wdt_clear;
  assign sleep_active = (r.fsm == st_sleep);

  // Narrow transfers are treated as word accesses
  logic unused_ok;
  assign unused_ok = ^{hsize, haddr[31:8]};

endmodule : lcd_core

`default_nettype wire

// ==== lcd_cfg.svh ====
// Offsets, field positions, reset values and opcode patterns of the literal/control decoder
`ifndef LCD_CFG_SVH
`define LCD_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets on the bus
// ----------------------------------------------------------------
`define LCD_OFF_CTRL    8'h00
`define LCD_OFF_STATUS  8'h04
`define LCD_OFF_WREG    8'h08
`define LCD_OFF_PC      8'h0c
`define LCD_OFF_TIMER   8'h10
`define LCD_OFF_PORT    8'h14

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define LCD_CTRL_RUN     0
`define LCD_CTRL_PSA_T0  1
`define LCD_CTRL_PS_LO   2
`define LCD_CTRL_PS_HI   4
`define LCD_CTRL_WAKE    5
`define LCD_CTRL_RESET   3'h0
`define LCD_PS_RESET     3'h0

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define LCD_ST_C      0
`define LCD_ST_DC     1
`define LCD_ST_Z      2
`define LCD_ST_PD     3
`define LCD_ST_TO     4
`define LCD_ST_GIE    5
`define LCD_ST_SLEEP  6
`define LCD_ST_RUN    7

// ----------------------------------------------------------------
// File addresses seen by the register exclusive-OR
// ----------------------------------------------------------------
`define LCD_FILE_TIMER  7'h01
`define LCD_FILE_PORT   7'h06

// ----------------------------------------------------------------
// Instruction encodings
// ----------------------------------------------------------------
`define LCD_GRP_LIT      2'h3
`define LCD_GRP_JMP      2'h2
`define LCD_GRP_BYTE     2'h0
`define LCD_NIB_LOAD     4'b00??
`define LCD_NIB_RETLIT   4'b01??
`define LCD_NIB_OR       4'h8
`define LCD_NIB_AND      4'h9
`define LCD_NIB_XOR      4'ha
`define LCD_NIB_SUB      4'b110?
`define LCD_NIB_ADD      4'b111?
`define LCD_WORD_WDT     14'h0064
`define LCD_WORD_SLEEP   14'h0063
`define LCD_WORD_INTERRUPT_RETURN_OP  14'h0009
`define LCD_WORD_RETURN  14'h0008
`define LCD_TOP_XOR_REGISTER_OP    6'h06

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define LCD_PC_W         13
`define LCD_STACK_DEPTH  8
`define LCD_RAM_WORDS    128

`endif

// ==== lcd_pkg.sv ====
// Types and the instruction decode function of the literal/control decoder
`default_nettype none
`include "lcd_cfg.svh"

package lcd_pkg;

  typedef enum logic [3:0] {
    no_operation           = 4'h0,
    add_literal_op         = 4'h1,
    and_literal_op         = 4'h2,
    or_literal_op          = 4'h3,
    xor_literal_op         = 4'h4,
    literal_subtract_op    = 4'h5,
    load_literal_op        = 4'h6,
    return_with_literal_op = 4'h7,
    call_op                = 4'h8,
    jump_op                = 4'h9,
    watchdog_clear_op      = 4'ha,
    sleep_op               = 4'hb,
    interrupt_return_op    = 4'hc,
    return_op              = 4'hd,
    xor_register_op        = 4'he
  } lcd_op_t;

  typedef enum logic [1:0] {
    st_exec  = 2'b00,
    st_flush = 2'b01,
    st_sleep = 2'b10,
    st_halt  = 2'b11
  } lcd_fsm_t;

  typedef struct packed {
    logic [7:0] value;
    logic       c;
    logic       dc;
    logic       z;
  } lcd_alu_res_t;

  typedef struct packed {
    lcd_fsm_t               fsm;
    logic [`LCD_PC_W-1:0]   pc;
    logic [7:0]             w;
    logic                   c;
    logic                   dc;
    logic                   z;
    logic                   timeout_flag;
    logic                   powerdown_flag;
    logic                   gie;
    logic                   run;
    logic                   psa_t0;
    logic [2:0]             ps;
    logic [7:0]             timer_zero_register;
    logic [7:0]             presc;
    logic [7:0]             port_latch;
    logic                   wdt_clear;
    logic                   bus_wr;
    logic [7:0]             bus_addr;
    logic [31:0]            hrdata;
  } lcd_state_t;

  function automatic lcd_op_t lcd_decode(input logic [13:0] iw);
    lcd_op_t op;
    op = no_operation;
    if (iw[13:12] == `LCD_GRP_LIT)
    begin
      casez (iw[11:8])
        `LCD_NIB_LOAD:   op = load_literal_op;
        `LCD_NIB_RETLIT: op = return_with_literal_op;
        `LCD_NIB_OR:     op = or_literal_op;
        `LCD_NIB_AND:    op = and_literal_op;
        `LCD_NIB_XOR:    op = xor_literal_op;
        `LCD_NIB_SUB:    op = literal_subtract_op;
        `LCD_NIB_ADD:    op = add_literal_op;
        default:         op = no_operation;
      endcase
    end
    else if (iw[13:12] == `LCD_GRP_JMP)
      op = iw[11] ? jump_op : call_op;
    else if (iw == `LCD_WORD_WDT)
      op = watchdog_clear_op;
    else if (iw == `LCD_WORD_SLEEP)
      op = sleep_op;
    else if (iw == `LCD_WORD_INTERRUPT_RETURN_OP)
      op = interrupt_return_op;
    else if (iw == `LCD_WORD_RETURN)
      op = return_op;
    else if (iw[13:8] == `LCD_TOP_XOR_REGISTER_OP)
      op = xor_register_op;
    return op;
  endfunction : lcd_decode

endpackage : lcd_pkg

`default_nettype wire

// ==== lcd_alu.sv ====
// Arithmetic and logic for the literal ops and the register exclusive-OR
`default_nettype none

module lcd_alu
  import lcd_pkg::*;
(
  input  wire lcd_pkg::lcd_op_t  op,
  input  wire logic [7:0]        lit,
  input  wire logic [7:0]        w,
  input  wire logic [7:0]        fval,
  output lcd_pkg::lcd_alu_res_t  res
);

  logic [8:0] sum;
  logic [4:0] low;
  logic [7:0] addend;

  always_comb
  begin
    // Subtract is literal plus the two's complement of the working register
    addend = (op == literal_subtract_op) ? ~w : w;
    sum    = {1'b0, lit} + {1'b0, addend} + {8'h00, op == literal_subtract_op};
    low    = {1'b0, lit[3:0]} + {1'b0, addend[3:0]} + {4'h0, op == literal_subtract_op};
    res.c  = sum[8];
    res.dc = low[4];
    unique case (op)
      add_literal_op, literal_subtract_op: res.value = sum[7:0];
      and_literal_op:                      res.value = lit & w;
      or_literal_op:                       res.value = lit | w;
      xor_literal_op:                      res.value = lit ^ w;
      xor_register_op:                     res.value = fval ^ w;
      default:                             res.value = lit;
    endcase
    res.z = (res.value == 8'h00);
  end

endmodule : lcd_alu

`default_nettype wire

// ==== lcd_stack.sv ====
// Return address stack, circular so that overflow overwrites the oldest entry
`default_nettype none
`include "lcd_cfg.svh"

module lcd_stack #(
  parameter int DEPTH = `LCD_STACK_DEPTH,
  parameter int WIDTH = `LCD_PC_W
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              push,
  input  wire logic              pop,
  input  wire logic [WIDTH-1:0]  din,
  output logic      [WIDTH-1:0]  top
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    ptr_reg;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ptr_reg <= '0;
    else if (push)
      ptr_reg <= ptr_reg + PW'(1);
    else if (pop)
      ptr_reg <= ptr_reg - PW'(1);
  end

  always_ff @(posedge hclk)
  begin
    if (push)
      mem[ptr_reg] <= din;
  end

  assign top = mem[ptr_reg - PW'(1)];

endmodule : lcd_stack

`default_nettype wire

// ==== lcd_prog_mem.sv ====
// Program memory model feeding fourteen-bit words to the core
`default_nettype none

module lcd_prog_mem (
  input  wire logic [12:0] addr,
  output logic      [13:0] data
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [13:0] mem [0:255];

  // Combinational read: the core executes the word in the cycle it is addressed
  // Upper address bits fold over, so stray fetches never read unknowns
  assign data = mem[addr[7:0]];
endmodule : lcd_prog_mem

`default_nettype wire

// ==== lcd_core_chk.sv ====
// Assertions on fetch order, watchdog pulse and standby of the decoder core
`default_nettype none

module lcd_core_chk #(
  parameter int PC_W = 13
) (
  input wire logic            hclk,
  input wire logic            hresetn,
  input wire logic [PC_W-1:0] prog_addr,
  input wire logic [13:0]     prog_data,
  input wire logic            wdt_clear,
  input wire logic            sleep_active
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // --------------------------------
  // Fetch sequences
  // --------------------------------
  // A moved address means the word shown before it was executed
  sequence s_moved;
    $changed(prog_addr);
  endsequence
  sequence s_branch;
    s_moved ##0 prog_addr != $past(prog_addr) + 1'b1;
  endsequence

  a_flush_hold: assert property (s_branch |=> $stable(prog_addr))
    else $error("fetch moved in flush cycle");
  a_jump_target: assert property (s_moved ##0 $past(prog_data[13:11]) == 3'b101
    |-> prog_addr == {$past(prog_addr[PC_W-1:11]), $past(prog_data[10:0])}) else $error("jump target wrong");
  a_call_target: assert property (s_moved ##0 $past(prog_data[13:11]) == 3'b100
    |-> prog_addr == {$past(prog_addr[PC_W-1:11]), $past(prog_data[10:0])}) else $error("call target wrong");
  a_literal_step: assert property (s_moved ##0 ($past(prog_data[13:12]) == 2'b11
    && $past(prog_data[11:10]) != 2'b01) |-> prog_addr == $past(prog_addr) + 1'b1) else $error("literal op not single");
  a_return_flush: assert property (s_moved ##0 $past(prog_data[13:10]) == 4'b1101
    |=> $stable(prog_addr)) else $error("literal return without flush");
  a_fixed_return: assert property (s_moved ##0 ($past(prog_data) == 14'h0008
    || $past(prog_data) == 14'h0009) |=> $stable(prog_addr)) else $error("return without flush");
  a_wdt_cause: assert property (s_moved ##0 $past(prog_data) == 14'h0064 |-> wdt_clear)
    else $error("watchdog clear not pulsed");
  a_wdt_pulse: assert property (wdt_clear |-> $past(prog_data) == 14'h0064 || $past(prog_data) == 14'h0063)
    else $error("watchdog clear without a clearing word");
  a_sleep_entry: assert property ($rose(sleep_active) |-> wdt_clear)
    else $error("standby entry without watchdog clear");
  a_sleep_hold: assert property (sleep_active && $past(sleep_active) |-> $stable(prog_addr))
    else $error("fetch moved in standby");
endmodule : lcd_core_chk

bind lcd_core lcd_core_chk #(.PC_W(PC_W)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .prog_addr(prog_addr),
  .prog_data(prog_data), .wdt_clear(wdt_clear), .sleep_active(sleep_active)
);

`default_nettype wire

// ==== testbench.sv ====
// Self-checking testbench of the literal and control decoder core
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        hclk        = 1'b0;
  logic        hresetn     = 1'b0;
  logic        hsel        = 1'b0;
  logic        hwrite      = 1'b0;
  logic [31:0] haddr       = 32'h0;
  logic [1:0]  htrans      = 2'h0;
  logic [2:0]  hsize       = 3'h2;
  logic [31:0] hwdata      = 32'h0;
  logic [7:0]  port_pin_in = 8'h00;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [12:0] prog_addr;
  logic [13:0] prog_data;
  logic [7:0]  port_out;
  logic        wdt_clear;
  logic        sleep_active;
  logic [31:0] v;
  int          n;
  int          errors      = 0;
  int          cmp_count   = 0;
  int          cycles      = 0;

  lcd_core DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .prog_addr(prog_addr),
    .prog_data(prog_data), .port_pin_in(port_pin_in), .port_out(port_out),
    .wdt_clear(wdt_clear), .sleep_active(sleep_active)
  );
  lcd_prog_mem PM (.addr(prog_addr), .data(prog_data));

  always #12.5 hclk = ~hclk;

  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      end_sim();
    end
  end

  task automatic end_sim;
    if (errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // --------------------------------
  // Bus and fetch helpers
  // --------------------------------
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    // Taken at the closing edge, before the slave's update of that edge lands
    v = hrdata;
  endtask : bus

  task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mk);
    bus(1'b0, a, 32'h0);
    chk(name, exp, v & mk);
  endtask : rchk

  // Counts cycles in n so callers can judge instruction timing
  task automatic wait_pc(input logic [12:0] a);
    n = 0;
    while (prog_addr !== a && n < 400)
    begin
      @(negedge hclk);
      n++;
    end
    chk("fetch address", {19'h0, a}, {19'h0, prog_addr});
  endtask : wait_pc

  task automatic restart;
    hresetn <= 1'b0;
    repeat (8) @(posedge hclk);
    foreach (PM.mem[i])
      PM.mem[i] = 14'h0000;
    hresetn <= 1'b1;
  endtask : restart

  task automatic lit_case(input logic [7:0] w0, input logic [13:0] op, input logic [7:0] wx,
                          input logic [2:0] fl, input logic [2:0] mk);
    restart();
    PM.mem[0] = {6'h30, w0};
    PM.mem[1] = op;
    PM.mem[2] = 14'h2802;
    bus(1'b1, 8'h00, 32'h1);
    wait_pc(13'h2);
    rchk("w", 8'h08, {24'h0, wx}, 32'hff);
    rchk("flags", 8'h04, {29'h0, fl & mk}, {29'h0, mk});
  endtask : lit_case

  task automatic t_flow;
    restart();
    PM.mem[0] = 14'h3055;
    PM.mem[1] = 14'h3fab;
    PM.mem[2] = 14'h2010;
    PM.mem[3] = 14'h2020;
    PM.mem[4] = 14'h2028;
    PM.mem[5] = 14'h2830;
    PM.mem[8'h10] = 14'h345a;
    PM.mem[8'h20] = 14'h0008;
    PM.mem[8'h28] = 14'h0009;
    PM.mem[8'h30] = 14'h2830;
    bus(1'b1, 8'h00, 32'h1);
    wait_pc(13'h1);
    wait_pc(13'h30);
    chk("cycles", 32'd14, n);
    rchk("w", 8'h08, 32'h5a, 32'hff);
    rchk("status", 8'h04, 32'h27, 32'h27);
  endtask : t_flow

  task automatic t_sleep;
    restart();
    PM.mem[0] = 14'h0063;
    PM.mem[1] = 14'h0064;
    PM.mem[2] = 14'h2802;
    rchk("status", 8'h04, 32'h18, 32'h98);
    bus(1'b1, 8'h00, 32'h1);
    wait_pc(13'h1);
    rchk("status", 8'h04, 32'h50, 32'h58);
    bus(1'b1, 8'h00, 32'h21);
    wait_pc(13'h2);
    rchk("status", 8'h04, 32'h18, 32'h58);
    chk("standby", 32'h0, {31'h0, sleep_active});
  endtask : t_sleep

  // Pins differ from the latch, so a latch-based update shows up
  task automatic t_xor;
    restart();
    port_pin_in <= 8'ha5;
    PM.mem[0] = 14'h300f;
    PM.mem[1] = 14'h0686;
    PM.mem[2] = 14'h0606;
    PM.mem[3] = 14'h2803;
    bus(1'b1, 8'h00, 32'h1);
    wait_pc(13'h3);
    chk("port out", 32'haa, {24'h0, port_out});
    rchk("w", 8'h08, 32'haa, 32'hff);
    rchk("unmapped", 8'h40, 32'h0, 32'hffffffff);
    chk("response", 32'h0, {31'h0, hresp});
  endtask : t_xor

  // Loop rewrites the timer every 3 cycles, well inside the 256 prescale
  task automatic t_timer;
    restart();
    PM.mem[0] = 14'h3000;
    PM.mem[1] = 14'h0681;
    PM.mem[2] = 14'h2801;
    bus(1'b1, 8'h00, 32'h1f);
    bus(1'b1, 8'h10, 32'h0);
    repeat (600) @(negedge hclk);
    rchk("timer", 8'h10, 32'h0, 32'hff);
  endtask : t_timer

  initial
  begin
    lit_case(8'h55, 14'h3e2b, 8'h80, 3'b010, 3'b111);
    lit_case(8'h55, 14'h3fab, 8'h00, 3'b111, 3'b111);
    lit_case(8'hf0, 14'h390f, 8'h00, 3'b100, 3'b100);
    lit_case(8'h00, 14'h3881, 8'h81, 3'b000, 3'b100);
    lit_case(8'hff, 14'h3aff, 8'h00, 3'b100, 3'b100);
    lit_case(8'h01, 14'h3c10, 8'h0f, 3'b001, 3'b111);
    lit_case(8'h02, 14'h3d01, 8'hff, 3'b000, 3'b111);
    lit_case(8'h11, 14'h3300, 8'h00, 3'b000, 3'b111);
    lit_case(8'h5a, 14'h3b44, 8'h5a, 3'b000, 3'b111);
    t_flow();
    t_sleep();
    t_xor();
    t_timer();
    end_sim();
  end
endmodule : testbench

`default_nettype wire
